/* hdl/faa_annunciator.sv */
module faa_annunciator #(
	parameter int ND = 3,
	parameter int NP = 8,
	parameter int MS_CYC = faa_pkg::MS_CYCLES,
	parameter int DUP_MS = faa_pkg::DUP_WINDOW_MS
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Fault source
	input wire logic fault_evt,
	input wire logic [2:0] fault_class,
	input wire logic [1:0] fault_func,
	input wire logic [6:0] fault_disp,
	input wire logic [faa_pkg::TEXT_CHARS*8-1:0] fault_text,
	input wire logic [faa_pkg::MINOR_CHARS*8-1:0] fault_minor,
	input wire logic [2:0] fault_cpu,
	// Mission elapsed time
	input wire logic [9:0] met_days,
	input wire logic [4:0] met_hours,
	input wire logic [5:0] met_min,
	input wire logic [5:0] met_sec,
	// Limit sense
	input wire logic limit_evt,
	input wire logic [$clog2(NP)-1:0] limit_idx,
	input wire logic [1:0] limit_dir,
	// Crew controls
	input wire logic warn_button,
	input wire logic [ND-1:0] ack_key,
	input wire logic [ND-1:0] message_clear_key,
	input wire logic history_erase_command,
	input wire logic [15:0] tone_ms,
	// Keyboard display units
	input wire logic [ND-1:0] entry_illegal,
	input wire logic [ND-1:0] kbd_key,
	input wire logic [ND-1:0] kbd_err,
	input wire logic [ND-1:0] kbd_clear,
	// Lamps and tones
	output logic backup_lamp,
	output logic master_lamp,
	output logic cw_tone,
	output logic systems_alert_lamp,
	output logic alert_tone,
	// Fault message line
	output logic line_valid,
	output logic line_flash,
	output faa_pkg::faa_entry_type line_msg,
	output logic [4:0] buf_count,
	output logic buf_shown,
	output logic [ND-1:0] illegal_msg,
	// History, arrows and scratch pads
	output faa_pkg::faa_entry_type [faa_pkg::HIST_DEPTH-1:0] hist_view,
	output logic [4:0] hist_count,
	output logic [NP-1:0] arrow_up,
	output logic [NP-1:0] arrow_down,
	output logic [ND-1:0][4:0] scratch_len,
	output logic [ND-1:0] err_marker
);
	localparam int DW = $clog2(MS_CYC);
	localparam logic [DW-1:0] DIV_LAST = DW'(MS_CYC - 1);
	localparam logic [4:0] STACK_MAX = 5'(faa_pkg::HIST_DEPTH - 1);
	localparam logic [4:0] PEND_MAX = 5'(faa_pkg::HIST_DEPTH);
	localparam logic [4:0] SCR_MAX = 5'(faa_pkg::SCRATCH_MAX);

	typedef enum logic [1:0] {LINE_EMPTY, LINE_FLASH, LINE_STATIC}
		faa_line_type;

	typedef struct packed {
		faa_line_type line;
		logic [4:0] depth;
		logic [4:0] pend;
		logic [ND-1:0] illegal;
		logic backup;
		logic master;
		logic cwt;
		logic alert;
		logic alt;
		logic [15:0] tone_left;
		logic [DW-1:0] ms_div;
		logic [NP-1:0] up;
		logic [NP-1:0] dn;
		logic [ND-1:0] errm;
		logic [ND-1:0][4:0] slen;
		logic vld;
		logic flash;
		logic bufz;
		faa_pkg::faa_entry_type msg;
	} faa_state_type;

	faa_state_type s_r, s_nxt;
	faa_pkg::faa_entry_type cand;
	logic dup;
	logic acc;
	logic acc2;
	logic acc3;
	logic ms_tick;
	logic ack_any;
	logic ack_ill;
	logic clr_shared;
	logic shown3;

	function automatic logic [4:0] sat_inc(input logic [4:0] v,
			input logic [4:0] lim);
		return (v < lim) ? v + 5'h01 : v;
	endfunction : sat_inc

	function automatic logic [4:0] sat_dec(input logic [4:0] v);
		return (v != 5'h00) ? v - 5'h01 : v;
	endfunction : sat_dec

	faa_fmt u_fmt (
		.func(fault_func),
		.disp_num(fault_disp),
		.text(fault_text),
		.minor(fault_minor),
		.is_cw(fault_class == faa_pkg::CLS_CW),
		.cpu(fault_cpu),
		.days(met_days),
		.hh(met_hours),
		.mm(met_min),
		.ss(met_sec),
		.entry(cand)
	);

	faa_hist #(.DUP_MS(DUP_MS)) u_hist (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.push(acc),
		.erase(history_erase_command),
		.ms_tick(ms_tick),
		.cand(cand),
		.dup(dup),
		.count(hist_count),
		.view(hist_view)
	);

	// Only classes 2 and 3 reach the shared line and the history
	assign acc = fault_evt && !dup && !history_erase_command &&
		(fault_class == faa_pkg::CLS_CW ||
		fault_class == faa_pkg::CLS_ALERT);
	assign acc2 = acc && fault_class == faa_pkg::CLS_CW;
	assign acc3 = acc && fault_class == faa_pkg::CLS_ALERT;
	assign ms_tick = s_r.ms_div == DIV_LAST;
	assign ack_any = |ack_key;
	assign ack_ill = |(ack_key & s_r.illegal);
	assign clr_shared = |(message_clear_key & ~s_r.illegal);
	assign shown3 = s_r.line != LINE_EMPTY &&
		hist_view[s_r.depth].cw != faa_pkg::CH_STAR;

	always_comb begin
		s_nxt = s_r;
		s_nxt.ms_div = ms_tick ? '0 : s_r.ms_div + 1'b1;
		// Clears come first so an event in the same cycle wins, except a fault event during an erase command and a key press during a kbd_clear
		if (warn_button) begin
			s_nxt.master = 1'b0;
			s_nxt.cwt = 1'b0;
		end
		if (ms_tick && s_r.tone_left != 16'h0000) begin
			s_nxt.tone_left = s_r.tone_left - 16'h0001;
			if (s_r.tone_left == 16'h0001)
				s_nxt.alt = 1'b0;
		end
		if (ack_ill) begin
			// Illegal entry stays; shared stack below it is dropped
			s_nxt.line = LINE_EMPTY;
			s_nxt.pend = '0;
			s_nxt.depth = '0;
		end else if (ack_any && s_r.line == LINE_FLASH) begin
			s_nxt.line = LINE_STATIC;
			if (shown3) begin
				s_nxt.alert = 1'b0;
				s_nxt.alt = 1'b0;
				s_nxt.tone_left = '0;
			end
		end else if (ack_any && s_r.line == LINE_STATIC &&
				s_r.pend != 5'h00) begin
			s_nxt.depth = sat_dec(s_r.depth);
			s_nxt.pend = sat_dec(s_r.pend);
			s_nxt.line = LINE_FLASH;
		end
		s_nxt.illegal = s_r.illegal & ~message_clear_key;
		if (clr_shared) begin
			s_nxt.line = LINE_EMPTY;
			s_nxt.pend = '0;
			s_nxt.depth = '0;
			s_nxt.backup = 1'b0;
			if (shown3) begin
				s_nxt.alert = 1'b0;
				s_nxt.alt = 1'b0;
				s_nxt.tone_left = '0;
			end
		end
		if (history_erase_command) begin
			s_nxt.line = LINE_EMPTY;
			s_nxt.pend = '0;
			s_nxt.depth = '0;
			s_nxt.illegal = '0;
		end
		s_nxt.illegal = s_nxt.illegal | entry_illegal;
		if (acc) begin
			if (s_nxt.line == LINE_EMPTY) begin
				s_nxt.line = LINE_FLASH;
				s_nxt.depth = '0;
			end else begin
				// Shown message moves down with the push; at the
				// bottom the index saturates onto the oldest entry
				s_nxt.depth = sat_inc(s_nxt.depth, STACK_MAX);
				s_nxt.pend = sat_inc(s_nxt.pend, PEND_MAX);
			end
		end
		if (acc2) begin
			s_nxt.backup = 1'b1;
			s_nxt.master = 1'b1;
			s_nxt.cwt = 1'b1;
		end
		if (acc3) begin
			s_nxt.alert = 1'b1;
			s_nxt.alt = tone_ms != 16'h0000;
			s_nxt.tone_left = tone_ms;
		end
		if (limit_evt) begin
			s_nxt.up[limit_idx] = limit_dir == faa_pkg::LIM_UP;
			s_nxt.dn[limit_idx] = limit_dir == faa_pkg::LIM_DOWN;
		end
		for (int d = 0; d < ND; d++) begin
			if (kbd_clear[d]) begin
				s_nxt.errm[d] = 1'b0;
				s_nxt.slen[d] = sat_dec(s_r.slen[d]);
			end else if (kbd_key[d] && !s_r.errm[d]) begin
				s_nxt.slen[d] = sat_inc(s_r.slen[d], SCR_MAX);
			end
			if (kbd_err[d])
				s_nxt.errm[d] = 1'b1;
		end
		// Line image follows the state one cycle later; bufz follows pend in the same cycle
		s_nxt.vld = s_r.line != LINE_EMPTY;
		s_nxt.flash = s_r.line == LINE_FLASH;
		s_nxt.msg = hist_view[s_r.depth];
		s_nxt.bufz = s_nxt.pend != 5'h00;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign backup_lamp = s_r.backup;
	assign master_lamp = s_r.master;
	assign cw_tone = s_r.cwt;
	assign systems_alert_lamp = s_r.alert;
	assign alert_tone = s_r.alt;
	assign line_valid = s_r.vld;
	assign line_flash = s_r.flash;
	assign line_msg = s_r.msg;
	assign buf_count = s_r.pend;
	assign buf_shown = s_r.bufz;
	assign illegal_msg = s_r.illegal;
	assign arrow_up = s_r.up;
	assign arrow_down = s_r.dn;
	assign scratch_len = s_r.slen;
	assign err_marker = s_r.errm;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	a_cls2_lamps: assert property (acc2 |=>
		backup_lamp && master_lamp && cw_tone ##1 line_valid)
		else $error("class 2 annunciation missing");
	a_cls3_lamp: assert property (acc3 |=>
		systems_alert_lamp ##1 line_valid)
		else $error("class 3 annunciation missing");
	a_illegal_quiet: assert property (entry_illegal != '0 &&
		!acc && !warn_button && !ack_any && !clr_shared |=>
		$stable(backup_lamp) && $stable(systems_alert_lamp) &&
		(illegal_msg & $past(entry_illegal)) == $past(entry_illegal))
		else $error("illegal entry annunciated wrongly");
	a_limit_quiet: assert property (limit_evt && !acc &&
		!warn_button && !ack_any && message_clear_key == '0 &&
		s_r.tone_left == 16'h0000 |=> $stable(master_lamp) &&
		$stable(systems_alert_lamp) && $stable(cw_tone) &&
		$stable(alert_tone))
		else $error("limit event touched lamps or tones");
	a_button_off: assert property (warn_button && !acc2 |=>
		!master_lamp && !cw_tone)
		else $error("warning button did not silence");
	a_ack_static: assert property (ack_any && !ack_ill &&
		!acc && s_r.line == LINE_FLASH && message_clear_key == '0 &&
		!history_erase_command |=> ##1 line_valid && !line_flash)
		else $error("confirm did not freeze line");
	a_clear_backup: assert property (clr_shared && !acc |=>
		!backup_lamp ##1 !line_valid)
		else $error("clear left backup lamp or line");
	a_tone_ends: assert property (alert_tone && ms_tick &&
		!acc3 && s_r.tone_left == 16'h0001 |=> !alert_tone)
		else $error("alert tone outlived its duration");
	a_dup_drop: assert property (fault_evt && dup && !ack_any &&
		message_clear_key == '0 && !history_erase_command |=>
		$stable(buf_count) && $stable(hist_count))
		else $error("duplicate message not suppressed");
	a_erase_all: assert property (history_erase_command &&
		entry_illegal == '0 |=> illegal_msg == '0 &&
		buf_count == 5'h00 && hist_count == 5'h00 ##1 !line_valid)
		else $error("erase left messages behind");
endmodule : faa_annunciator

/* hdl/faa_pkg.sv */
// Contract
// - Class 2 lights backup, master lamps, tone, message
// - Class 3 lights alert lamp, tone, message
// - Class 5 only from illegal entry, message only
// - Class 0 shows arrow, nothing else
// - Warning button kills master lamp and tone
// - Confirm stops flashing, then steps stack
// - Clear removes backup message and lamp
// - Confirm on class 3 silences alert lamp
// - Alert tone ends after crew-selected time
// - Clear on unconfirmed class 3 silences alert
// - Illegal entry cleared only by clear key or erase command
// - Keyboard error marker and right-to-left clears
// - Messages use five fixed fields
// - Major field: prefix plus subsystem, 14 chars
// - Minor field is four characters
// - Asterisk marks class 2 backup only
// - Message carries computer identity and time
// - Class 5 local, classes 2/3 global
// - History of 15, newest on top
// - Suppress duplicate within window of top
// - Pending counter, blank at zero, clear resets
// - Erase command empties history and lines
package faa_pkg;
	localparam int HIST_DEPTH = 15;
	localparam int MAJOR_CHARS = 14;
	localparam int MINOR_CHARS = 4;
	localparam int TEXT_CHARS = 11;
	localparam int CLK_HZ = 200000000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
	localparam int DUP_WINDOW_MS = 4800;
	localparam int SCRATCH_MAX = 31;
	localparam logic [2:0] CLS_CW = 3'h2;
	localparam logic [2:0] CLS_ALERT = 3'h3;
	localparam logic [1:0] FUNC_GNC = 2'h1;
	localparam logic [1:0] FUNC_SM = 2'h2;
	localparam logic [1:0] LIM_UP = 2'h1;
	localparam logic [1:0] LIM_DOWN = 2'h2;
	localparam logic [7:0] CH_BLANK = 8'h20;
	localparam logic [7:0] CH_S = 8'h53;
	localparam logic [7:0] CH_G = 8'h47;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_STAR = 8'h2a;
	localparam logic [6:0] DIGIT_BASE = 7'h0a;

	typedef struct packed {
		logic [MAJOR_CHARS*8-1:0] major;
		logic [MINOR_CHARS*8-1:0] minor;
		logic [7:0] cw;
		logic [2:0] cpu;
		logic [9:0] days;
		logic [4:0] hh;
		logic [5:0] mm;
		logic [5:0] ss;
	} faa_entry_type;
endpackage : faa_pkg

/* hdl/faa_fmt.sv */
module faa_fmt (
	// Fault description
	input wire logic [1:0] func,
	input wire logic [6:0] disp_num,
	input wire logic [faa_pkg::TEXT_CHARS*8-1:0] text,
	input wire logic [faa_pkg::MINOR_CHARS*8-1:0] minor,
	input wire logic is_cw,
	input wire logic [2:0] cpu,
	// Mission elapsed time
	input wire logic [9:0] days,
	input wire logic [4:0] hh,
	input wire logic [5:0] mm,
	input wire logic [5:0] ss,
	// Formatted message
	output faa_pkg::faa_entry_type entry
);
	function automatic logic [7:0] digit(input logic [6:0] v);
		return faa_pkg::CH_ZERO + {1'b0, v};
	endfunction : digit

	logic [23:0] prefix;

	always_comb begin
		// Display reference is blank when no display applies
		case (func)
			faa_pkg::FUNC_GNC: prefix = {faa_pkg::CH_G,
				digit(disp_num / faa_pkg::DIGIT_BASE),
				digit(disp_num % faa_pkg::DIGIT_BASE)};
			faa_pkg::FUNC_SM: prefix = {faa_pkg::CH_S,
				digit(disp_num / faa_pkg::DIGIT_BASE),
				digit(disp_num % faa_pkg::DIGIT_BASE)};
			default: prefix = {3{faa_pkg::CH_BLANK}};
		endcase
		entry.major = {prefix, text};
		entry.minor = minor;
		entry.cw = is_cw ? faa_pkg::CH_STAR : faa_pkg::CH_BLANK;
		entry.cpu = cpu;
		entry.days = days;
		entry.hh = hh;
		entry.mm = mm;
		entry.ss = ss;
	end
endmodule : faa_fmt

/* hdl/faa_hist.sv */
module faa_hist #(
	parameter int DUP_MS = faa_pkg::DUP_WINDOW_MS
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Control
	input wire logic push,
	input wire logic erase,
	input wire logic ms_tick,
	input faa_pkg::faa_entry_type cand,
	// Status
	output logic dup,
	output logic [4:0] count,
	output faa_pkg::faa_entry_type [faa_pkg::HIST_DEPTH-1:0] view
);
	localparam int AW = $clog2(DUP_MS + 1);
	localparam logic [AW-1:0] DUP_LIM = AW'(DUP_MS);
	localparam logic [4:0] FULL = 5'(faa_pkg::HIST_DEPTH);

	typedef struct packed {
		faa_pkg::faa_entry_type [faa_pkg::HIST_DEPTH-1:0] ent;
		logic [4:0] cnt;
		logic [AW-1:0] age;
	} faa_hist_type;

	faa_hist_type s_r, s_nxt;

	always_comb begin
		s_nxt = s_r;
		// Age of the top entry, in milliseconds, saturating
		if (ms_tick && s_r.age < DUP_LIM)
			s_nxt.age = s_r.age + 1'b1;
		if (erase) begin
			s_nxt.ent = '0;
			s_nxt.cnt = '0;
		end else if (push) begin
			// Oldest entry falls off the bottom
			for (int i = faa_pkg::HIST_DEPTH - 1; i > 0; i--)
				s_nxt.ent[i] = s_r.ent[i-1];
			s_nxt.ent[0] = cand;
			if (s_r.cnt < FULL)
				s_nxt.cnt = s_r.cnt + 1'b1;
			s_nxt.age = '0;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign dup = s_r.cnt != 5'h00 && s_r.age < DUP_LIM &&
		s_r.ent[0].major == cand.major &&
		s_r.ent[0].minor == cand.minor;
	assign count = s_r.cnt;
	assign view = s_r.ent;

	a_hist_push: assert property (@(posedge sys_clk)
		disable iff (!reset_n) push && !erase |=>
		view[0] == $past(cand) && view[1] == $past(view[0]) &&
		count != 5'h00)
		else $error("history push did not shift");
endmodule : faa_hist

/* verification/faa_crew.sv */
module faa_crew #(
	parameter int ND = 3
) (
	// Clock
	input wire logic sys_clk,
	// Crew controls and keyboard units
	output logic warn_button,
	output logic history_erase_command,
	output logic [ND-1:0] ack_key,
	output logic [ND-1:0] message_clear_key,
	output logic [ND-1:0] entry_illegal,
	output logic [ND-1:0] kbd_key,
	output logic [ND-1:0] kbd_err,
	output logic [ND-1:0] kbd_clear
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		warn_button = 1'b0;
		history_erase_command = 1'b0;
		{ack_key, message_clear_key, entry_illegal} = '0;
		{kbd_key, kbd_err, kbd_clear} = '0;
	end
	// One-cycle press on display d, launched just after an edge
	task automatic press(input int k, input int d);
		logic [ND-1:0] b;
		b = '0;
		b[d] = 1'b1;
		@(posedge sys_clk);
		#1;
		case (k)
			0: warn_button = 1'b1;
			1: ack_key = b;
			2: message_clear_key = b;
			3: history_erase_command = 1'b1;
			4: entry_illegal = b;
			5: kbd_key = b;
			6: kbd_err = b;
			default: kbd_clear = b;
		endcase
		@(posedge sys_clk);
		#1;
		warn_button = 1'b0;
		history_erase_command = 1'b0;
		{ack_key, message_clear_key, entry_illegal} = '0;
		{kbd_key, kbd_err, kbd_clear} = '0;
	endtask : press
endmodule : faa_crew

/* verification/tb_fault_alarm_annunciator.sv */
module tb_fault_alarm_annunciator;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int ND = 3;
	localparam int NP = 8;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic fault_evt = 1'b0;
	logic [2:0] fault_class = 3'h0;
	logic [1:0] fault_func = faa_pkg::FUNC_SM;
	logic [6:0] fault_disp = 7'h58;
	logic [87:0] fault_text = '0;
	logic [31:0] fault_minor = '0;
	logic [2:0] fault_cpu = 3'h4;
	logic [9:0] met_days = 10'h002;
	logic [4:0] met_hours = 5'h0e;
	logic [5:0] met_min = 6'h2c;
	logic [5:0] met_sec = 6'h0c;
	logic limit_evt = 1'b0;
	logic [2:0] limit_idx = 3'h0;
	logic [1:0] limit_dir = 2'h0;
	logic [15:0] tone_ms = 16'h0002;
	logic warn_button, history_erase_command;
	logic [ND-1:0] ack_key, message_clear_key, entry_illegal;
	logic [ND-1:0] kbd_key, kbd_err, kbd_clear, illegal_msg, err_marker;
	logic backup_lamp, master_lamp, cw_tone, systems_alert_lamp;
	logic alert_tone, line_valid, line_flash, buf_shown;
	logic [4:0] buf_count, hist_count;
	logic [NP-1:0] arrow_up, arrow_down;
	logic [ND-1:0][4:0] scratch_len;
	faa_pkg::faa_entry_type line_msg;
	faa_pkg::faa_entry_type e;
	faa_pkg::faa_entry_type [faa_pkg::HIST_DEPTH-1:0] hist_view;
	int miscompares = 0;
	int n_compared = 0;
	int cyc = 0;

	always #2.5 sys_clk = ~sys_clk;

	// Short tick and window keep the run in a few hundred cycles
	faa_annunciator #(.ND(ND), .NP(NP), .MS_CYC(10), .DUP_MS(4)) DUT (
		.sys_clk, .reset_n, .fault_evt, .fault_class, .fault_func,
		.fault_disp, .fault_text, .fault_minor, .fault_cpu, .met_days,
		.met_hours, .met_min, .met_sec, .limit_evt, .limit_idx,
		.limit_dir, .warn_button, .ack_key, .message_clear_key,
		.history_erase_command, .tone_ms, .entry_illegal, .kbd_key,
		.kbd_err, .kbd_clear, .backup_lamp, .master_lamp, .cw_tone,
		.systems_alert_lamp, .alert_tone, .line_valid, .line_flash,
		.line_msg, .buf_count, .buf_shown, .illegal_msg, .hist_view,
		.hist_count, .arrow_up, .arrow_down, .scratch_len, .err_marker);

	faa_crew #(.ND(ND)) crew (.sys_clk, .warn_button,
		.history_erase_command, .ack_key, .message_clear_key,
		.entry_illegal, .kbd_key, .kbd_err, .kbd_clear);

	task automatic complete_run;
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			complete_run();
		end
	end

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step

	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : chk

	// Key press, then one edge more so the message line has settled
	task automatic key(input int k, input int d);
		crew.press(k, d);
		step(1);
	endtask : key

	task automatic fire(input logic [2:0] c, input logic [87:0] t,
			input logic [31:0] m);
		@(posedge sys_clk);
		#1;
		fault_evt = 1'b1;
		fault_class = c;
		fault_text = t;
		fault_minor = m;
		@(posedge sys_clk);
		#1;
		fault_evt = 1'b0;
		step(1);
		e.major = {faa_pkg::CH_S, 16'h3838, t};
		if (fault_func == faa_pkg::FUNC_GNC)
			e.major[111:104] = faa_pkg::CH_G;
		else if (fault_func != faa_pkg::FUNC_SM)
			e.major[111:88] = {3{faa_pkg::CH_BLANK}};
		e.minor = m;
		e.cw = (c == 3'h2) ? faa_pkg::CH_STAR : faa_pkg::CH_BLANK;
		e.cpu = fault_cpu;
		e.days = met_days;
		e.hh = met_hours;
		e.mm = met_min;
		e.ss = met_sec;
	endtask : fire

	task automatic t_cw;
		fire(3'h2, "EVAP OUT T ", "1   ");
		chk({backup_lamp, master_lamp, cw_tone} === 3'h7, "cw lamps");
		chk({line_valid, line_flash} === 2'h3, "cw line");
		chk(line_msg === e, "message fields");
		chk(hist_view[0] === e && hist_count === 5'h01, "hist top");
		key(0, 0);
		chk({backup_lamp, master_lamp, cw_tone} === 3'h4, "warn");
		key(1, 0);
		chk({line_valid, line_flash} === 2'h2, "ack static");
		key(2, 2);
		chk({backup_lamp, line_valid} === 2'h0, "clear");
		fire(3'h2, "EVAP OUT T ", "1   ");
		chk(hist_count === 5'h01 && !line_valid, "dup kept");
		step(60);
		fire(3'h2, "EVAP OUT T ", "1   ");
		chk(hist_count === 5'h02 && line_valid, "dup late");
		key(2, 0);
		// The late copy lit the master lamp again
		key(0, 0);
	endtask : t_cw

	task automatic t_alert;
		fire(3'h3, "FREON LOOP ", "2   ");
		chk({systems_alert_lamp, alert_tone} === 2'h3, "alert on");
		chk({backup_lamp, master_lamp} === 2'h0, "no cw");
		chk(line_msg === e && line_valid === 1'b1, "alert msg");
		// 2 ms at 10 cycles a tick, plus up to one tick of phase
		step(35);
		chk({systems_alert_lamp, alert_tone} === 2'h2, "tone end");
		key(1, 1);
		chk({systems_alert_lamp, line_flash} === 2'h0, "ack");
		key(2, 0);
		tone_ms = 16'h0064;
		fault_func = faa_pkg::FUNC_GNC;
		fire(3'h3, "FREON LOOP ", "3   ");
		chk(line_msg === e, "gnc prefix");
		key(2, 1);
		chk({systems_alert_lamp, alert_tone, line_valid} === 3'h0,
			"clear unacked");
	endtask : t_alert

	task automatic t_stack;
		fire(3'h2, "STACK      ", "A   ");
		fire(3'h3, "STACK      ", "B   ");
		fire(3'h3, "STACK      ", "C   ");
		chk(buf_count === 5'h02 && buf_shown, "pending");
		chk(line_msg.minor === "A   ", "first kept");
		key(1, 0);
		key(1, 0);
		chk(line_msg.minor === "B   " && line_flash, "next");
		chk(buf_count === 5'h01, "pending dec");
		key(2, 2);
		chk({buf_count, buf_shown, line_valid} === 7'h0, "reset");
		key(0, 0);
	endtask : t_stack

	task automatic t_illegal;
		tone_ms = 16'h0000;
		fault_func = 2'h0;
		fire(3'h3, "ILL        ", "I   ");
		chk(line_msg === e, "blank prefix");
		key(1, 0);
		key(4, 1);
		chk(illegal_msg === 3'h2, "local");
		chk({backup_lamp, master_lamp, systems_alert_lamp} === 3'h0,
			"no lamp");
		key(1, 1);
		chk(illegal_msg === 3'h2 && !line_valid, "ack");
		key(2, 0);
		chk(illegal_msg === 3'h2, "other clear");
		key(2, 1);
		chk(illegal_msg === 3'h0, "own clear");
	endtask : t_illegal

	task automatic t_limit;
		@(posedge sys_clk);
		#1;
		limit_evt = 1'b1;
		limit_idx = 3'h5;
		limit_dir = faa_pkg::LIM_UP;
		@(posedge sys_clk);
		#1;
		limit_idx = 3'h2;
		limit_dir = faa_pkg::LIM_DOWN;
		@(posedge sys_clk);
		#1;
		limit_evt = 1'b0;
		step(1);
		chk(arrow_up === 8'h20 && arrow_down === 8'h04, "arrows");
		chk({line_valid, backup_lamp, alert_tone} === 3'h0, "quiet");
	endtask : t_limit

	task automatic t_kbd;
		repeat (3) key(5, 2);
		chk(scratch_len[2] === 5'h03, "keys");
		key(6, 2);
		chk(err_marker === 3'h4, "marker");
		key(7, 2);
		chk(!err_marker[2] && scratch_len[2] === 5'h02, "clr 1");
		key(7, 2);
		chk(scratch_len[2] === 5'h01, "clr 2");
	endtask : t_kbd

	task automatic t_hist;
		for (int i = 0; i < 16; i++) begin
			fire(3'h3, "HIST       ", {"M", 8'h40 + 8'(i), "  "});
		end
		chk(hist_count === 5'h0f, "depth");
		chk(hist_view[0].minor === "MO  ", "newest");
		chk(hist_view[14].minor === "MA  ", "oldest");
		chk(buf_count === 5'h0f, "pending max");
		key(3, 0);
		chk({hist_count, line_valid} === 6'h0, "erase");
	endtask : t_hist

	initial begin
		step(2);
		reset_n = 1'b1;
		step(1);
		t_cw();
		t_alert();
		t_stack();
		t_illegal();
		t_limit();
		t_kbd();
		t_hist();
		complete_run();
	end
endmodule : tb_fault_alarm_annunciator
